// *** rtl/hbm_pkg.sv ***
// Package with mode codes, widths, reset values and states of the host bus front end.
package hbm_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int WIN_W = 2;
	localparam int SYNC_W = 3;
	// Positions of the strobes inside the synchroniser vector.
	localparam int SYNC_RD = 0;
	localparam int SYNC_WR = 1;
	localparam int SYNC_ALE = 2;
	// Configuration codes on the mode pins.
	localparam logic [1:0] MODE_EXT_SEL = 2'h0;
	localparam logic [1:0] MODE_INT_DEC = 2'h1;
	// The decoder matches when every address bit above the window field is zero.
	localparam logic [ADDR_W-WIN_W-1:0] DEC_MATCH = 8'h00;
	localparam logic [DATA_W-1:0] ADDR_LO_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h7;
	// Core clock must be at least this multiple of the host bus clock.
	localparam int CLK_RATIO_MIN = 4;
	localparam int CLK_MHZ = 125;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_HOLD = 2'b10
	} hbm_state_t;
endpackage : hbm_pkg

// *** rtl/hbm_sync.sv ***
// Two-flop synchroniser for the host strobes, with a third stage kept for edge detection.
`timescale 1ns/1ps
module hbm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout,
	output logic [W-1:0] dout_prev
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] dout_r;
	logic [W-1:0] dout_nxt;
	logic [W-1:0] prev_r;
	logic [W-1:0] prev_nxt;

	// The first stage feeds only the second one, so edges are judged on settled values.
	always_comb begin
		meta_nxt = din;
		dout_nxt = meta_r;
		prev_nxt = dout_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST_VAL;
			dout_r <= RST_VAL;
			prev_r <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			dout_r <= dout_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign dout = dout_r;
	assign dout_prev = prev_r;
endmodule : hbm_sync

// *** rtl/hbm_host_port.sv ***
// Host bus front end: mode select, address latch, internal decoder, request and ready handshake.
// Operation
// - Multiplexed mode latches low address byte from shared bus on the address strobe.
// - Multiplexed mode decodes select from latched low byte plus two upper pins.
// - Access window chosen by the two lowest address bits only.
// - Asynchronous mode drives active-low ready per access; host waits for it.
// - Asynchronous mode uses separate eight data and ten address lines, no strobe latch.
// - Code zero-zero disables internal decoder; external active-low select qualifies accesses.
// - Code zero-one: synchronized falling read/write edge requests only under internal select.
// - Code zero-zero: synchronized falling read/write edge requests under external select.
`timescale 1ns/1ps
module hbm_host_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] mode_cfg,
	input wire logic async_host_mode_bit,
	input wire logic [hbm_pkg::DATA_W-1:0] data_bus_pins_i,
	input wire logic [hbm_pkg::ADDR_W-1:0] address_bus_pins,
	input wire logic ale,
	input wire logic chip_select_n_pin,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic ram_done,
	input wire logic [hbm_pkg::DATA_W-1:0] ram_rdata,
	output logic [hbm_pkg::DATA_W-1:0] data_bus_pins_o,
	output logic data_bus_pins_oe_n,
	output logic wait_ack_n,
	output logic req_valid,
	output logic req_write,
	output logic [hbm_pkg::ADDR_W-1:0] req_addr,
	output logic [hbm_pkg::WIN_W-1:0] req_window,
	output logic [hbm_pkg::DATA_W-1:0] req_wdata
);
	logic [hbm_pkg::SYNC_W-1:0] strb_s;
	logic [hbm_pkg::SYNC_W-1:0] strb_p;
	logic rd_fall;
	logic wr_fall;
	logic strb_idle;
	logic mode_dec;
	logic mode_ext;
	logic [hbm_pkg::ADDR_W-1:0] cur_addr;
	logic sel;
	hbm_pkg::hbm_state_t st_r;
	hbm_pkg::hbm_state_t st_nxt;
	logic [hbm_pkg::DATA_W-1:0] addr_lo_r;
	logic [hbm_pkg::DATA_W-1:0] addr_lo_nxt;
	logic [hbm_pkg::DATA_W-1:0] dout_r;
	logic [hbm_pkg::DATA_W-1:0] dout_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic rdy_n_r;
	logic rdy_n_nxt;
	logic rv_r;
	logic rv_nxt;
	logic rw_r;
	logic rw_nxt;
	logic [hbm_pkg::ADDR_W-1:0] ra_r;
	logic [hbm_pkg::ADDR_W-1:0] ra_nxt;
	logic [hbm_pkg::DATA_W-1:0] rd_r;
	logic [hbm_pkg::DATA_W-1:0] rd_nxt;

	// Strobes are resynchronised; this only works if the core clock outruns the bus clock.
	hbm_sync #(
		.W(hbm_pkg::SYNC_W),
		.RST_VAL(hbm_pkg::SYNC_RST)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({ale, write_strobe_n, read_strobe_n}),
		.dout(strb_s),
		.dout_prev(strb_p)
	);

	// Edge detection and select qualification per configuration code.
	always_comb begin
		rd_fall = strb_p[hbm_pkg::SYNC_RD] && !strb_s[hbm_pkg::SYNC_RD];
		wr_fall = strb_p[hbm_pkg::SYNC_WR] && !strb_s[hbm_pkg::SYNC_WR];
		strb_idle = strb_s[hbm_pkg::SYNC_RD] && strb_s[hbm_pkg::SYNC_WR];
		mode_dec = (mode_cfg == hbm_pkg::MODE_INT_DEC);
		mode_ext = (mode_cfg == hbm_pkg::MODE_EXT_SEL);
		// Upper two pins join the latched low byte; separate bus uses all ten pins.
		cur_addr = mode_dec ? {address_bus_pins[9:8], addr_lo_r} : address_bus_pins;
		// Decoder ignores the external pin; external mode ignores the decoder.
		sel = (mode_dec && (cur_addr[hbm_pkg::ADDR_W-1:hbm_pkg::WIN_W] == hbm_pkg::DEC_MATCH))
			|| (mode_ext && !chip_select_n_pin);
	end

	// Address latch follows the shared bus while the strobe is high, freezes on its fall.
	always_comb begin
		addr_lo_nxt = addr_lo_r;
		if (mode_dec && ale) begin
			addr_lo_nxt = data_bus_pins_i;
		end
	end

	// Access sequencer: request, wait for memory, then hold until both strobes return high.
	always_comb begin
		st_nxt = st_r;
		dout_nxt = dout_r;
		oe_n_nxt = oe_n_r;
		rdy_n_nxt = rdy_n_r;
		rv_nxt = 1'b0;
		rw_nxt = rw_r;
		ra_nxt = ra_r;
		rd_nxt = rd_r;
		unique case (st_r)
			hbm_pkg::ST_IDLE: begin
				oe_n_nxt = 1'b1;
				rdy_n_nxt = 1'b1;
				if ((rd_fall || wr_fall) && sel) begin
					st_nxt = hbm_pkg::ST_BUSY;
					rv_nxt = 1'b1;
					rw_nxt = wr_fall;
					ra_nxt = cur_addr;
					rd_nxt = data_bus_pins_i;
				end
			end
			hbm_pkg::ST_BUSY: begin
				if (ram_done) begin
					st_nxt = hbm_pkg::ST_HOLD;
					dout_nxt = rw_r ? dout_r : ram_rdata;
					oe_n_nxt = rw_r;
					// Ready goes low only in the separate-bus handshake mode.
					rdy_n_nxt = !(mode_ext && async_host_mode_bit);
				end
			end
			hbm_pkg::ST_HOLD: begin
				// Ready stays low until the host ends its cycle, so no answer is lost.
				if (strb_idle) begin
					st_nxt = hbm_pkg::ST_IDLE;
					oe_n_nxt = 1'b1;
					rdy_n_nxt = 1'b1;
				end
			end
			default: begin
				st_nxt = hbm_pkg::ST_IDLE;
				oe_n_nxt = 1'b1;
				rdy_n_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= hbm_pkg::ST_IDLE;
			addr_lo_r <= hbm_pkg::ADDR_LO_RST;
			dout_r <= hbm_pkg::DATA_RST;
			oe_n_r <= 1'b1;
			rdy_n_r <= 1'b1;
			rv_r <= 1'b0;
			rw_r <= 1'b0;
			ra_r <= hbm_pkg::ADDR_RST;
			rd_r <= hbm_pkg::DATA_RST;
		end else begin
			st_r <= st_nxt;
			addr_lo_r <= addr_lo_nxt;
			dout_r <= dout_nxt;
			oe_n_r <= oe_n_nxt;
			rdy_n_r <= rdy_n_nxt;
			rv_r <= rv_nxt;
			rw_r <= rw_nxt;
			ra_r <= ra_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign data_bus_pins_o = dout_r;
	assign data_bus_pins_oe_n = oe_n_r;
	assign wait_ack_n = rdy_n_r;
	assign req_valid = rv_r;
	assign req_write = rw_r;
	assign req_addr = ra_r;
	assign req_window = ra_r[hbm_pkg::WIN_W-1:0];
	assign req_wdata = rd_r;

	// Checks on the sequencer and its pins.
	AST_REQ_DEC: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == hbm_pkg::ST_IDLE && rd_fall && mode_dec && sel) |=> req_valid && !req_write)
		else $error("read edge under decoder select gave no request");
	AST_NO_REQ_UNSEL: assert property (@(posedge clk) disable iff (!rst_n)
		(!sel) |=> !req_valid)
		else $error("request issued without select");
	AST_DEC_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
		(req_valid && mode_dec) |-> req_addr[hbm_pkg::ADDR_W-1:hbm_pkg::WIN_W] == hbm_pkg::DEC_MATCH)
		else $error("decoder selected a nonzero upper address");
	AST_WINDOW: assert property (@(posedge clk) disable iff (!rst_n)
		req_valid |-> req_window == req_addr[1:0])
		else $error("window not taken from low address bits");
	AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_dec && ale) |=> addr_lo_r == $past(data_bus_pins_i))
		else $error("low address not latched from shared bus");
	AST_EXT_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == hbm_pkg::ST_IDLE && wr_fall && mode_dec && sel && chip_select_n_pin) |=> req_valid)
		else $error("external select pin blocked a decoded access");
	AST_READY: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == hbm_pkg::ST_BUSY && ram_done && mode_ext && async_host_mode_bit) |=> !wait_ack_n)
		else $error("ready not given after memory answer");
	AST_READY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(!wait_ack_n && !strb_idle) |=> !wait_ack_n)
		else $error("ready dropped before the host ended its cycle");
	AST_SEP_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == hbm_pkg::ST_IDLE && (rd_fall || wr_fall) && sel && mode_ext)
		|=> req_addr == $past(address_bus_pins))
		else $error("separate address pins not taken directly");
	COV_DEC_READ: cover property (@(posedge clk) disable iff (!rst_n) req_valid && !req_write && mode_dec);
	COV_EXT_WRITE: cover property (@(posedge clk) disable iff (!rst_n) req_valid && req_write && mode_ext);
	COV_READY: cover property (@(posedge clk) disable iff (!rst_n) $fell(wait_ack_n));
endmodule : hbm_host_port

// *** tb/hbm_host_model.sv ***
// Host controller model: drives the host pins for one byte access and waits for ready where there is one.
`timescale 1ns/1ps
module hbm_host_model (
	input wire logic clk,
	input wire logic wait_ack_n,
	input wire logic [7:0] dout,
	output logic [7:0] host_data,
	output logic [9:0] host_addr,
	output logic ale,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n
);
	// Idle pins at time zero.
	initial begin
		host_data = 8'h00;
		host_addr = 10'h000;
		ale = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
	end

	// One access; released data lines show the inverse of their last value, so stale data never looks valid.
	task automatic access(input logic [1:0] m, input logic wr, input logic [9:0] a, input logic [7:0] wd,
			input logic cs, output logic [7:0] rd, output logic ak);
		int n;
		n = 0;
		@(posedge clk);
		if (m == 2'h1) begin
			host_data <= a[7:0];
			host_addr <= {a[9:8], ~a[7:0]}; // Only the two upper pins carry address here.
			ale <= 1'b1;
			@(posedge clk);
			ale <= 1'b0;
			@(posedge clk);
		end else begin
			host_addr <= a;
			ale <= ~ale;
		end
		cs_n <= (m == 2'h1) ? 1'b1 : ~cs;
		host_data <= wr ? wd : ~a[7:0];
		rd_n <= wr;
		wr_n <= ~wr;
		repeat (4) @(posedge clk); // The host strobe spans at least four core cycles.
		while (wait_ack_n !== 1'b0 && n < 12) begin
			@(posedge clk);
			n++;
		end
		ak = (wait_ack_n === 1'b0);
		rd = dout;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		cs_n <= 1'b1;
		host_data <= ~host_data;
		repeat (6) @(posedge clk);
	endtask : access
endmodule : hbm_host_model

// *** tb/testbench.sv ***
// Self-checking bench of the host bus front end with a host model and a memory responder.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] mode_cfg = 2'h0;
	logic async_bit = 1'b0;
	logic ram_done = 1'b0;
	logic [7:0] ram_rdata = 8'h00;
	logic [7:0] host_data, dout, got_wd;
	logic [9:0] host_addr, req_addr, got_addr;
	logic [1:0] req_window, got_win;
	logic ale, cs_n, rd_n, wr_n, oe_n, wait_ack_n, req_valid, req_write, got_wr;
	logic [7:0] req_wdata;
	logic [31:0] seed = 32'h13;
	int fail_count = 0;
	int num_checks = 0;
	int nreq = 0;
	int dly = 0;
	int oe_cnt = 0;

	always #4 clk = ~clk;

	hbm_host_model host (.clk(clk), .wait_ack_n(wait_ack_n), .dout(dout), .host_data(host_data),
		.host_addr(host_addr), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
	hbm_host_port dut (.clk(clk), .rst_n(rst_n), .mode_cfg(mode_cfg), .async_host_mode_bit(async_bit),
		.data_bus_pins_i(host_data), .address_bus_pins(host_addr), .ale(ale), .chip_select_n_pin(cs_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .ram_done(ram_done), .ram_rdata(ram_rdata),
		.data_bus_pins_o(dout), .data_bus_pins_oe_n(oe_n), .wait_ack_n(wait_ack_n), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_window(req_window), .req_wdata(req_wdata));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Contents that the memory responder returns for an address.
	function automatic logic [7:0] exp_rd(input logic [9:0] a);
		return a[7:0] ^ {a[9:8], 6'h2D};
	endfunction : exp_rd

	// Whether an access should reach memory at all.
	function automatic logic exp_req(input logic [1:0] m, input logic cs, input logic [9:0] a);
		return (m == 2'h1) ? (a[9:2] == 8'h00) : (m == 2'h0) ? cs : 1'b0;
	endfunction : exp_req

	// Memory responder: captures each request and answers after a random one to three cycles.
	always @(posedge clk) begin
		ram_done <= 1'b0;
		if (req_valid === 1'b1) begin
			nreq <= nreq + 1;
			got_addr <= req_addr;
			got_win <= req_window;
			got_wr <= req_write;
			got_wd <= req_wdata;
			ram_rdata <= exp_rd(req_addr);
			dly <= 1 + int'(xs() % 3);
		end else if (dly == 1) begin
			ram_done <= 1'b1;
			dly <= 0;
		end else if (dly > 1) begin
			dly <= dly - 1;
		end
	end

	// Counts the cycles in which the device drives the data pins, so a read that never drives them is caught.
	always @(posedge clk) begin
		if (oe_n === 1'b0) begin
			oe_cnt <= oe_cnt + 1;
		end
	end

	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One access followed by checks of the request, the answer and the return to idle.
	task automatic run(input logic [1:0] m, input logic bit_set, input logic wr, input logic [9:0] a, input logic cs);
		logic [7:0] wd, rd;
		logic ak, ex;
		int n0;
		int o0;
		wd = 8'(xs());
		n0 = nreq;
		o0 = oe_cnt;
		ex = exp_req(m, cs, a);
		mode_cfg <= m;
		async_bit <= bit_set;
		host.access(m, wr, a, wd, cs, rd, ak);
		chk("req_count", 10'(n0 + ex), 10'(nreq));
		chk("ready_seen", 10'(ex && m == 2'h0 && bit_set), 10'(ak));
		chk("oe_n_idle", 10'h001, 10'(oe_n));
		chk("oe_driven", 10'(ex && !wr), 10'(oe_cnt != o0));
		chk("ready_idle", 10'h001, 10'(wait_ack_n));
		if (ex) begin
			chk("req_addr", a, got_addr);
			chk("req_window", 10'(a[1:0]), 10'(got_win));
			chk("req_write", 10'(wr), 10'(got_wr));
			chk("data", wr ? 10'(wd) : 10'(exp_rd(a)), wr ? 10'(got_wd) : 10'(rd));
		end
	endtask : run

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// Watchdog sized well beyond about sixty accesses of at most twenty-five cycles each.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end

	initial begin
		logic [9:0] a;
		logic [1:0] m;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			run(2'h1, 1'b0, i[0], 10'(i), 1'b0); // Every window, reads and writes.
		end
		run(2'h1, 1'b0, 1'b0, 10'h004, 1'b0); // Bit two set misses the decoder.
		run(2'h1, 1'b0, 1'b1, 10'h080, 1'b0);
		run(2'h0, 1'b1, 1'b0, 10'h3FF, 1'b1);
		run(2'h0, 1'b0, 1'b1, 10'h2A5, 1'b1);
		run(2'h0, 1'b1, 1'b0, 10'h001, 1'b0); // No external select, no request.
		run(2'h2, 1'b1, 1'b0, 10'h000, 1'b1);
		run(2'h3, 1'b0, 1'b1, 10'h001, 1'b1);
		$display("test corners done");
		for (int i = 0; i < 48; i++) begin
			m = 2'(xs());
			a = 10'(xs());
			if (m == 2'h1) begin
				a[9:8] = 2'h0;
				if (xs() % 2 == 0) a[7:2] = 6'h00;
			end
			run(m, 1'(xs()), 1'(xs()), a, 1'(xs()));
		end
		$display("test random done");
		stop_test();
	end
endmodule : testbench
